// file: hdl/esq_event_status_queue.sv
// Purpose: Event reporting registers, interrupt status queue and request line.
// Assumes: One read or write strobe per access; inputs synchronous to CORE_CLK.
// Notes:   Read data appears one cycle after the read strobe and then holds.
//          Reading the queue or an event register directly consumes that entry.
//          Counters clear on a direct read; an increment in that cycle still counts.
//          The request line stays high while any queue entry is pending.
//
// Functional notes
// - Enabled events set bits, presented through queue.
// - Posted enabled event drives interrupt request high.
// - Queue sources include receive, transmit, buffer events.
// - Missed-frame and collision overflows also queue.
// - Memory mode queue at 0120h, writes ignored.
// - I/O mode queue readable at 0008h.
// - Queue low six bits name reported register.
// - Queue upper ten bits carry register data.
// - Receive configuration read/write at 0102h, id 000011.
// - Fixed low six bits identify each register.
`timescale 1ns/100ps
module esq_event_status_queue (
    // Clock and synchronous reset.
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // Host register bus.
    input  wire logic        HOST_IO_MODE,
    input  wire logic [15:0] HOST_ADDR,
    input  wire logic        HOST_RD,
    input  wire logic        HOST_WR,
    input  wire logic [15:0] HOST_WDATA,
    output logic      [15:0] HOST_RDATA,
    // Event inputs and their interrupt enables.
    input  wire logic [9:0]  RX_EVENT_IN,
    input  wire logic [9:0]  TX_EVENT_IN,
    input  wire logic [9:0]  TX_IRQ_EN,
    input  wire logic [9:0]  BUF_EVENT_IN,
    input  wire logic [9:0]  BUF_IRQ_EN,
    // Counter increments and overflow report enables.
    input  wire logic        MISS_INC,
    input  wire logic        MISS_OVF_IRQ_EN,
    input  wire logic        COL_INC,
    input  wire logic        COL_OVF_IRQ_EN,
    input  wire logic        REFL_INC,
    // Live status inputs, read directly.
    input  wire logic [9:0]  LINE_STATUS_IN,
    input  wire logic [9:0]  SELF_STATUS_IN,
    input  wire logic [9:0]  BUS_STATUS_IN,
    // Configuration and interrupt request outputs.
    output logic      [9:0]  RX_CFG_OUT,
    output logic             IRQ
);

    // Builds a register word from its ten data bits and its identifier.
    function automatic logic [15:0] word_of(input logic [9:0] data, input logic [5:0] id);
        word_of = {data, id};
    endfunction

    // Counter step: a read clears, an increment in the same cycle still counts.
    function automatic logic [9:0] count_next(input logic [9:0] cnt, input logic clr,
                                              input logic inc);
        logic [9:0] base;
        base = clr ? 10'h000 : cnt;
        count_next = inc ? 10'(base + 10'h001) : base;
    endfunction

    // Event step: new bits win over a clear that falls in the same cycle.
    function automatic logic [9:0] event_next(input logic [9:0] cur, input logic clr,
                                              input logic hit, input logic [9:0] bits);
        event_next = (clr ? 10'h000 : cur) | (hit ? bits : 10'h000);
    endfunction

    // True when a memory-mode strobe addresses the given page offset.
    function automatic logic page_hit(input logic strobe, input logic [15:0] addr,
                                      input logic [15:0] off);
        page_hit = strobe && addr == off;
    endfunction

    // Registered state.
    logic [9:0]  rx_cfg_reg;
    logic [9:0]  rx_evt_reg;
    logic [9:0]  tx_evt_reg;
    logic [9:0]  buf_evt_reg;
    logic [9:0]  miss_cnt_reg;
    logic [9:0]  col_cnt_reg;
    logic [9:0]  refl_cnt_reg;
    logic        miss_ovf_reg;
    logic        col_ovf_reg;
    logic [9:0]  miss_ovf_data_reg;
    logic [9:0]  col_ovf_data_reg;
    logic [15:0] rdata_reg;

    // Next-state values, all formed by continuous assignments.
    logic [9:0]  rx_cfg_next;
    logic [9:0]  rx_evt_next;
    logic [9:0]  tx_evt_next;
    logic [9:0]  buf_evt_next;
    logic [9:0]  miss_cnt_next;
    logic [9:0]  col_cnt_next;
    logic [9:0]  refl_cnt_next;
    logic        miss_ovf_next;
    logic        col_ovf_next;
    logic [15:0] rdata_next;
    logic [9:0]  miss_ovf_data_next;
    logic [9:0]  col_ovf_data_next;

    // Address decode: memory-mode page offsets, or the I/O-mode queue port.
    wire mem_acc      = !HOST_IO_MODE;
    wire rd_queue     = HOST_RD && ((mem_acc && HOST_ADDR == esq_pkg::OFF_QUEUE) ||
                        (!mem_acc && HOST_ADDR == esq_pkg::IO_OFF_QUEUE));
    wire rd_mem       = HOST_RD && mem_acc;
    wire wr_mem       = HOST_WR && mem_acc;
    wire rd_rx_cfg    = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_RX_CFG);
    wire wr_rx_cfg    = page_hit(wr_mem, HOST_ADDR, esq_pkg::OFF_RX_CFG);
    wire rd_rx_evt    = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_RX_EVENT);
    wire rd_tx_evt    = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_TX_EVENT);
    wire rd_buf_evt   = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_BUF_EVENT);
    wire rd_miss      = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_MISS_CNT);
    wire rd_col       = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_COL_CNT);
    wire rd_line      = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_LINE_ST);
    wire rd_self      = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_SELF_ST);
    wire rd_bus       = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_BUS_ST);
    wire rd_refl      = page_hit(rd_mem, HOST_ADDR, esq_pkg::OFF_REFL_CNT);

    // An event is posted only when at least one of its bits has its enable set.
    wire rx_hit       = |(RX_EVENT_IN & rx_cfg_reg & esq_pkg::RX_IRQ_MASK);
    wire tx_hit       = |(TX_EVENT_IN & TX_IRQ_EN);
    wire buf_hit      = |(BUF_EVENT_IN & BUF_IRQ_EN);

    // Queue selection in fixed priority: receive, transmit, buffer, missed, collision.
    wire rx_pend      = |rx_evt_reg;
    wire tx_pend      = |tx_evt_reg;
    wire buf_pend     = |buf_evt_reg;
    wire sel_rx       = rx_pend;
    wire sel_tx       = !rx_pend && tx_pend;
    wire sel_buf      = !rx_pend && !tx_pend && buf_pend;
    wire sel_miss     = !rx_pend && !tx_pend && !buf_pend && miss_ovf_reg;
    wire sel_col      = !rx_pend && !tx_pend && !buf_pend && !miss_ovf_reg
                        && col_ovf_reg;

    wire [15:0] queue_word =
        sel_rx   ? word_of(rx_evt_reg, esq_pkg::ID_RX_EVENT) :
        sel_tx   ? word_of(tx_evt_reg, esq_pkg::ID_TX_EVENT) :
        sel_buf  ? word_of(buf_evt_reg, esq_pkg::ID_BUF_EVENT) :
        sel_miss ? word_of(miss_ovf_data_reg, esq_pkg::ID_MISS_CNT) :
        sel_col  ? word_of(col_ovf_data_reg, esq_pkg::ID_COL_CNT) :
                   16'h0000;

    // Reading the queue consumes the presented entry; direct reads consume too.
    wire clr_rx       = (rd_queue && sel_rx) || rd_rx_evt;
    wire clr_tx       = (rd_queue && sel_tx) || rd_tx_evt;
    wire clr_buf      = (rd_queue && sel_buf) || rd_buf_evt;
    wire clr_miss_ovf = (rd_queue && sel_miss) || rd_miss;
    wire clr_col_ovf  = (rd_queue && sel_col) || rd_col;

    // Overflow is reported when the counter's top bit first becomes set.
    wire miss_top_now = |(miss_cnt_reg & esq_pkg::CNT_OVF_BIT);
    wire miss_top_new = |(miss_cnt_next & esq_pkg::CNT_OVF_BIT);
    wire col_top_now  = |(col_cnt_reg & esq_pkg::CNT_OVF_BIT);
    wire col_top_new  = |(col_cnt_next & esq_pkg::CNT_OVF_BIT);
    wire miss_ovf_evt = MISS_OVF_IRQ_EN && !miss_top_now && miss_top_new;
    wire col_ovf_evt  = COL_OVF_IRQ_EN && !col_top_now && col_top_new;

    // New event bits win over a clear in the same cycle.
    assign rx_evt_next   = event_next(rx_evt_reg, clr_rx, rx_hit, RX_EVENT_IN);
    assign tx_evt_next   = event_next(tx_evt_reg, clr_tx, tx_hit, TX_EVENT_IN);
    assign buf_evt_next  = event_next(buf_evt_reg, clr_buf, buf_hit, BUF_EVENT_IN);
    // The overflow report keeps the count seen at the moment it was posted.
    assign miss_ovf_data_next = miss_ovf_evt ? miss_cnt_next : miss_ovf_data_reg;
    assign col_ovf_data_next  = col_ovf_evt ? col_cnt_next : col_ovf_data_reg;
    assign miss_cnt_next = count_next(miss_cnt_reg, rd_miss, MISS_INC);
    assign col_cnt_next  = count_next(col_cnt_reg, rd_col, COL_INC);
    assign refl_cnt_next = count_next(refl_cnt_reg, rd_refl, REFL_INC);
    assign miss_ovf_next = miss_ovf_evt || (miss_ovf_reg && !clr_miss_ovf);
    assign col_ovf_next  = col_ovf_evt || (col_ovf_reg && !clr_col_ovf);
    assign rx_cfg_next   = wr_rx_cfg ? HOST_WDATA[15:6] : rx_cfg_reg;

    // Read data mux; unmapped offsets and the I/O-mode non-queue ports read zero.
    assign rdata_next =
        rd_queue   ? queue_word :
        rd_rx_cfg  ? word_of(rx_cfg_reg, esq_pkg::ID_RX_CFG) :
        rd_rx_evt  ? word_of(rx_evt_reg, esq_pkg::ID_RX_EVENT) :
        rd_tx_evt  ? word_of(tx_evt_reg, esq_pkg::ID_TX_EVENT) :
        rd_buf_evt ? word_of(buf_evt_reg, esq_pkg::ID_BUF_EVENT) :
        rd_miss    ? word_of(miss_cnt_reg, esq_pkg::ID_MISS_CNT) :
        rd_col     ? word_of(col_cnt_reg, esq_pkg::ID_COL_CNT) :
        rd_line    ? word_of(LINE_STATUS_IN, esq_pkg::ID_LINE_ST) :
        rd_self    ? word_of(SELF_STATUS_IN, esq_pkg::ID_SELF_ST) :
        rd_bus     ? word_of(BUS_STATUS_IN, esq_pkg::ID_BUS_ST) :
        rd_refl    ? word_of(refl_cnt_reg, esq_pkg::ID_REFL_CNT) :
        HOST_RD    ? 16'h0000 : rdata_reg;

    // Receive configuration is the only register the host can write.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rx_cfg_reg <= esq_pkg::RX_CFG_RESET;
        end else begin
            rx_cfg_reg <= rx_cfg_next;
        end
    end

    // Receive events collect until the host consumes them.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rx_evt_reg <= 10'h000;
        end else begin
            rx_evt_reg <= rx_evt_next;
        end
    end

    // Transmit events collect until the host consumes them.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            tx_evt_reg <= 10'h000;
        end else begin
            tx_evt_reg <= tx_evt_next;
        end
    end

    // Buffer events collect until the host consumes them.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            buf_evt_reg <= 10'h000;
        end else begin
            buf_evt_reg <= buf_evt_next;
        end
    end

    // Missed-frame count wraps at ten bits.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            miss_cnt_reg <= 10'h000;
        end else begin
            miss_cnt_reg <= miss_cnt_next;
        end
    end

    // Collision count wraps at ten bits.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            col_cnt_reg <= 10'h000;
        end else begin
            col_cnt_reg <= col_cnt_next;
        end
    end

    // Reflectometer count wraps at ten bits and posts no report.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            refl_cnt_reg <= 10'h000;
        end else begin
            refl_cnt_reg <= refl_cnt_next;
        end
    end

    // Missed-frame overflow entry waits in the queue until consumed.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            miss_ovf_reg <= 1'b0;
        end else begin
            miss_ovf_reg <= miss_ovf_next;
        end
    end

    // Collision overflow entry waits in the queue until consumed.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            col_ovf_reg <= 1'b0;
        end else begin
            col_ovf_reg <= col_ovf_next;
        end
    end

    // Count captured with the missed-frame overflow report.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            miss_ovf_data_reg <= 10'h000;
        end else begin
            miss_ovf_data_reg <= miss_ovf_data_next;
        end
    end

    // Count captured with the collision overflow report.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            col_ovf_data_reg <= 10'h000;
        end else begin
            col_ovf_data_reg <= col_ovf_data_next;
        end
    end

    // Read data is captured with the strobe and held until the next read.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Data outputs come straight from flip-flops.
    assign HOST_RDATA = rdata_reg;
    assign RX_CFG_OUT = rx_cfg_reg;
    // The request stays high while any entry waits in the queue.
    assign IRQ = rx_pend || tx_pend || buf_pend || miss_ovf_reg || col_ovf_reg;

endmodule // esq_event_status_queue

// file: include/esq_pkg.sv
// Purpose: Shared constants for the event status queue block.
// Assumes: 16-bit host registers, ten data bits above a six-bit identifier.
// Notes:   Offsets are page offsets in memory mode or port offsets in I/O mode.
package esq_pkg;
    localparam logic [15:0] OFF_RX_CFG     = 16'h0102;
    localparam logic [15:0] OFF_QUEUE      = 16'h0120;
    localparam logic [15:0] OFF_RX_EVENT   = 16'h0124;
    localparam logic [15:0] OFF_TX_EVENT   = 16'h0128;
    localparam logic [15:0] OFF_BUF_EVENT  = 16'h012c;
    localparam logic [15:0] OFF_MISS_CNT   = 16'h0130;
    localparam logic [15:0] OFF_COL_CNT    = 16'h0132;
    localparam logic [15:0] OFF_LINE_ST    = 16'h0134;
    localparam logic [15:0] OFF_SELF_ST    = 16'h0136;
    localparam logic [15:0] OFF_BUS_ST     = 16'h0138;
    localparam logic [15:0] OFF_REFL_CNT   = 16'h013c;
    localparam logic [15:0] IO_OFF_QUEUE   = 16'h0008;

    localparam logic [5:0]  ID_RX_CFG      = 6'h03;
    localparam logic [5:0]  ID_RX_EVENT    = 6'h04;
    localparam logic [5:0]  ID_TX_EVENT    = 6'h08;
    localparam logic [5:0]  ID_BUF_EVENT   = 6'h0c;
    localparam logic [5:0]  ID_MISS_CNT    = 6'h10;
    localparam logic [5:0]  ID_COL_CNT     = 6'h12;
    localparam logic [5:0]  ID_LINE_ST     = 6'h14;
    localparam logic [5:0]  ID_SELF_ST     = 6'h16;
    localparam logic [5:0]  ID_BUS_ST      = 6'h18;
    localparam logic [5:0]  ID_REFL_CNT    = 6'h1c;

    localparam int          ID_LSB         = 0;
    localparam int          ID_W           = 6;
    localparam int          DATA_LSB       = 6;
    localparam int          DATA_W         = 10;

    localparam logic [9:0]  RX_CFG_RESET   = 10'h000;
    localparam logic [9:0]  RX_IRQ_MASK    = 10'h1c4;
    localparam logic [9:0]  CNT_OVF_BIT    = 10'h200;
endpackage

// file: testbench/esq_host_model.sv
// Purpose: Host bus master for the event status queue.
// Assumes: Each access is launched at a falling clock edge.
// Notes:   A released address or data bus shows the inverse of its last value.
`timescale 1ns/100ps
module esq_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    output logic             io_mode,
    output logic [15:0]      addr,
    output logic             rd,
    output logic             wr,
    output logic [15:0]      wdata
);
    initial begin
        {io_mode, rd, wr, addr, wdata} = '0;
    end
    task automatic access(input logic m, w, input logic [15:0] a, d, output logic [15:0] q);
        io_mode = m;
        addr = a;
        wdata = d;
        rd = !w;
        wr = w;
        @(negedge clk);
        {rd, wr} = 2'b00;
        addr = ~a;
        wdata = ~d;
        q = rdata;
        @(negedge clk);
    endtask
endmodule // esq_host_model

// file: testbench/esq_checker_assertions.sv
// Purpose: Port assertions for the event status queue.
// Assumes: Host strobes last one cycle.
// Notes:   Attached to the design by bind.
`timescale 1ns/100ps
module esq_checker (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        HOST_IO_MODE,
    input wire logic [15:0] HOST_ADDR,
    input wire logic        HOST_RD,
    input wire logic        HOST_WR,
    input wire logic [15:0] HOST_WDATA,
    input wire logic [15:0] HOST_RDATA,
    input wire logic [9:0]  TX_EVENT_IN,
    input wire logic [9:0]  TX_IRQ_EN,
    input wire logic        MISS_INC,
    input wire logic [9:0]  RX_CFG_OUT,
    input wire logic        IRQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    wire cfg_sel = !HOST_IO_MODE && HOST_ADDR == esq_pkg::OFF_RX_CFG;
    wire q_sel = HOST_ADDR == (HOST_IO_MODE ? esq_pkg::IO_OFF_QUEUE : esq_pkg::OFF_QUEUE);
    property p_cfg_id; HOST_RD && cfg_sel |=> HOST_RDATA[5:0] == 6'h03; endproperty
    a_cfg_id: assert property (p_cfg_id) else $error("cfg id");
    property p_cfg_wr; HOST_WR && cfg_sel |=> RX_CFG_OUT == $past(HOST_WDATA[15:6]); endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("cfg write");
    property p_q_ro;
        HOST_WR && !HOST_IO_MODE && HOST_ADDR == esq_pkg::OFF_QUEUE |=> $stable(RX_CFG_OUT);
    endproperty
    a_q_ro: assert property (p_q_ro) else $error("queue write");
    property p_q_id;
        HOST_RD && q_sel |=> HOST_RDATA[5:0] inside {6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h12};
    endproperty
    a_q_id: assert property (p_q_id) else $error("queue id");
    property p_q_empty; HOST_RD && q_sel && !IRQ |=> HOST_RDATA == 16'h0000; endproperty
    a_q_empty: assert property (p_q_empty) else $error("empty queue");
    property p_irq; |(TX_EVENT_IN & TX_IRQ_EN) |=> IRQ; endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_tx_id;
        HOST_RD && !HOST_IO_MODE && HOST_ADDR == esq_pkg::OFF_TX_EVENT |=> HOST_RDATA[5:0] == 6'h08;
    endproperty
    a_tx_id: assert property (p_tx_id) else $error("tx id");
    property p_hold; !HOST_RD |=> $stable(HOST_RDATA); endproperty
    a_hold: assert property (p_hold) else $error("read hold");
    c_queue: cover property (HOST_RD && q_sel && IRQ);
    c_io: cover property (HOST_RD && q_sel && HOST_IO_MODE);
    c_ovf: cover property (MISS_INC ##1 IRQ);
endmodule // esq_checker
bind esq_event_status_queue esq_checker u_chk (.CORE_CLK, .RST_N, .HOST_IO_MODE, .HOST_ADDR,
    .HOST_RD, .HOST_WR, .HOST_WDATA, .HOST_RDATA, .TX_EVENT_IN, .TX_IRQ_EN, .MISS_INC,
    .RX_CFG_OUT, .IRQ);

// file: testbench/event_status_queue_tb_top.sv
// Purpose: Self-checking bench for the event status queue.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Expected event-test queue words come from a bench-side queue.
`timescale 1ns/100ps
module event_status_queue_tb_top;
    logic        clk = 0, rst_n = 0, io_mode, rd, wr, irq, miss_inc = 0, col_inc = 0, refl = 0;
    logic [15:0] addr, wdata, rdata, q, wd, ca, exp_q[$];
    logic [9:0]  rx_ev = 0, tx_ev = 0, tx_en = 0, buf_ev = 0, cfg_out, r = 0;
    logic [5:0]  id;
    int          miscompares = 0, samples_checked = 0, cycles = 0, seed = 77;
    always #2 clk = ~clk;
    esq_host_model host (.clk(clk), .rdata(rdata), .io_mode(io_mode), .addr(addr), .rd(rd),
        .wr(wr), .wdata(wdata));
    esq_event_status_queue uut (.CORE_CLK(clk), .RST_N(rst_n), .HOST_IO_MODE(io_mode),
        .HOST_ADDR(addr), .HOST_RD(rd), .HOST_WR(wr), .HOST_WDATA(wdata), .HOST_RDATA(rdata),
        .RX_EVENT_IN(rx_ev), .TX_EVENT_IN(tx_ev), .TX_IRQ_EN(tx_en), .BUF_EVENT_IN(buf_ev),
        .BUF_IRQ_EN(tx_en), .MISS_INC(miss_inc), .MISS_OVF_IRQ_EN(1'b1), .COL_INC(col_inc),
        .COL_OVF_IRQ_EN(1'b1), .REFL_INC(refl), .LINE_STATUS_IN(r), .SELF_STATUS_IN(~r),
        .BUS_STATUS_IN(r), .RX_CFG_OUT(cfg_out), .IRQ(irq));
    task automatic chk(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic m, input logic [15:0] a, exp, input string what);
        host.access(m, 1'b0, a, 16'h0000, q);
        chk(what, q, exp);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        rd_chk(0, esq_pkg::OFF_QUEUE, 16'h0000, "empty queue");
        rd_chk(0, esq_pkg::OFF_RX_CFG, 16'h0003, "cfg reset");
        r = 10'($random(seed));
        rd_chk(0, esq_pkg::OFF_LINE_ST, {r, 6'h14}, "line status");
        rd_chk(0, esq_pkg::OFF_SELF_ST, {~r, 6'h16}, "self status");
        rd_chk(0, esq_pkg::OFF_BUS_ST, {r, 6'h18}, "bus status");
        rd_chk(1, esq_pkg::OFF_RX_CFG, 16'h0000, "io unmapped");
        rd_chk(0, 16'h0100, 16'h0000, "unmapped");
        wd = 16'($random(seed));
        host.access(0, 1, esq_pkg::OFF_RX_CFG, wd, q);
        host.access(0, 1, esq_pkg::OFF_QUEUE, ~wd, q);
        rd_chk(0, esq_pkg::OFF_RX_CFG, {wd[15:6], 6'h03}, "cfg");
        chk("cfg out", {6'h00, cfg_out}, {6'h00, wd[15:6]});
        $display("register test done");
        host.access(0, 1, esq_pkg::OFF_RX_CFG, 16'hffc0, q);
        r = 10'($random(seed));
        tx_ev = r | 10'h001;
        rx_ev = r & 10'h23b;
        @(negedge clk);
        {rx_ev, tx_ev} = '0;
        @(negedge clk);
        chk("masked irq", {15'h0000, irq}, 16'h0000);
        rd_chk(0, esq_pkg::OFF_TX_EVENT, 16'h0008, "masked tx");
        rd_chk(0, esq_pkg::OFF_RX_EVENT, 16'h0004, "masked rx");
        tx_en = 10'h3ff;
        rx_ev = r | 10'h100;
        tx_ev = ~r | 10'h001;
        buf_ev = (r ^ 10'h155) | 10'h001;
        exp_q = '{{rx_ev, 6'h04}, {tx_ev, 6'h08}, {buf_ev, 6'h0c}};
        @(negedge clk);
        {rx_ev, tx_ev, buf_ev} = '0;
        @(negedge clk);
        chk("irq", {15'h0000, irq}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            ca = i[0] ? esq_pkg::IO_OFF_QUEUE : esq_pkg::OFF_QUEUE;
            rd_chk(i[0], ca, exp_q.size() ? exp_q.pop_front() : 16'h0000, "queue");
        end
        $display("event test done");
        for (int k = 0; k < 2; k++) begin
            repeat (512) begin
                {miss_inc, col_inc, refl} = {k == 0, k == 1, 1'b1};
                @(negedge clk);
            end
            {miss_inc, col_inc, refl} = '0;
            id = k ? 6'h12 : 6'h10;
            ca = k ? esq_pkg::OFF_COL_CNT : esq_pkg::OFF_MISS_CNT;
            rd_chk(0, esq_pkg::OFF_QUEUE, {10'h200, id}, "overflow");
            rd_chk(0, ca, {10'h200, id}, "counter");
            rd_chk(0, ca, {10'h000, id}, "cleared");
        end
        rd_chk(0, esq_pkg::OFF_REFL_CNT, 16'h001c, "refl wrap");
        $display("counter test done");
        tally_and_finish();
    end
endmodule // event_status_queue_tb_top
